// file: logic/option_byte_config_decoder.sv
// Configuration byte decoder: fetches the byte at flash 0x0080 after reset release,
// holds the core in reset until decoded, applies the oscillator wait, drives pin and clock controls.
// Assumes flash_ack arrives on hclk; reset pin, mode signals and variant strap come from pins.

// Contract
// - Config byte at flash 0x0080, variant A fixes bits 7,4
// - Variant A bits 6:5 select oscillator wait
// - Wait only when crystal is clock source
// - Bit 3 one: reset pin, zero: input port
// - Low pin before fetch keeps device in reset
// - Variant A bits 2:1 select clock source
// - Variant A clock choice claims shared oscillator pins
// - Bit 0 one makes slow oscillator unstoppable
// - Unstoppable oscillator forces watchdog clock to it
// - Stoppable: watchdog clock off in halt, stop, other
// - Running slow oscillator still feeds interval timer in stop
// - Variant B bits 7:5 fixed, bit 4 pull-up
// - Variant B code 00 prohibited, 01 claims pin
// - Variant B port mode pull-up from port register
module option_byte_config_decoder
  import cfg_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        variant_b,
  output logic             flash_req,
  output logic [15:0]      flash_addr,
  input  wire logic        flash_ack,
  input  wire logic [7:0]  flash_data,
  input  wire logic        rst_pin_n,
  input  wire logic        halt_mode,
  input  wire logic        stop_mode,
  input  wire logic        wdt_sel_slow,
  input  wire logic        rst_port_pullup_bit,
  output logic             core_reset_n,
  output logic             clk_src_xtal,
  output logic             clk_src_ext,
  output logic             clk_src_hs_int,
  output logic             clk_sel_error,
  output logic             osc_in_pin_clk,
  output logic             osc_out_pin_clk,
  output logic             rst_pin_is_reset,
  output logic             rst_pin_pullup_on,
  output logic             slow_osc_run,
  output logic             wdt_clk_en,
  output logic             wdt_clk_force_slow,
  output logic             tmr8_clk_en
);
  load_state_t          state;
  load_state_t          next_state;
  logic [7:0]           cfg;
  logic [7:0]           next_cfg;
  logic                 var_b;
  logic                 next_var_b;
  logic [WAIT_W-1:0]    wait_cnt;
  logic [WAIT_W-1:0]    next_wait_cnt;
  logic [WAIT_W-1:0]    wait_len;
  logic                 pin_n;
  logic                 halt_s;
  logic                 stop_s;
  logic                 var_s;
  logic                 stop_bit;
  logic [1:0]           clk_code;
  logic                 lock;
  logic [7:0]           status;
  logic                 loaded;

  pin_sync u_rst_sync (.hclk(hclk), .hresetn(hresetn), .din(rst_pin_n), .dout(pin_n));
  pin_sync u_halt_sync (.hclk(hclk), .hresetn(hresetn), .din(halt_mode), .dout(halt_s));
  pin_sync u_stop_sync (.hclk(hclk), .hresetn(hresetn), .din(stop_mode), .dout(stop_s));
  pin_sync u_var_sync (.hclk(hclk), .hresetn(hresetn), .din(variant_b), .dout(var_s));

  ahb_cfg_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .cfg_byte  (cfg),
    .status    (status),
    .stop_bit  (stop_bit)
  );

  assign loaded   = (state == ST_STAB) || (state == ST_RUN);
  assign clk_code = {cfg[BIT_CLK_HI], cfg[BIT_CLK_LO]};
  assign lock     = cfg[BIT_LOCK];

  always_comb
  begin
    case ({cfg[BIT_STAB_HI], cfg[BIT_STAB_LO]})
      2'h0:    wait_len = WAIT_W'(1 << WAIT_EXP_0);
      2'h1:    wait_len = WAIT_W'(1 << WAIT_EXP_1);
      2'h2:    wait_len = WAIT_W'(1 << WAIT_EXP_2);
      default: wait_len = WAIT_W'(1 << WAIT_EXP_3);
    endcase
  end

  always_comb
  begin
    next_state    = state;
    next_cfg      = cfg;
    next_var_b    = var_b;
    next_wait_cnt = wait_cnt;
    case (state)
      ST_FETCH:
      begin
        if (pin_n)
          next_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (!pin_n)
          next_state = ST_FETCH;
        else if (flash_ack)
        begin
          next_cfg   = flash_data;
          next_var_b = var_s;
          next_state = ST_STAB;
          next_wait_cnt = WAIT_W'(0);
        end
      end
      ST_STAB:
      begin
        if (var_b || clk_code != CLK_XTAL || wait_cnt == wait_len - WAIT_W'(1))
          next_state = ST_RUN;
        else
          next_wait_cnt = wait_cnt + WAIT_W'(1);
      end
      ST_RUN:
      begin
        next_state = ST_RUN;
      end
      default:
      begin
        next_state = ST_FETCH;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state    <= ST_FETCH;
      cfg      <= CFG_BYTE_RESET;
      var_b    <= 1'b0;
      wait_cnt <= '0;
    end
    else
    begin
      state    <= next_state;
      cfg      <= next_cfg;
      var_b    <= next_var_b;
      wait_cnt <= next_wait_cnt;
    end
  end

  assign flash_req  = (state == ST_WAIT);
  assign flash_addr = CFG_FLASH_ADDR;
  assign status     = {4'h0, var_b, clk_sel_error, state};

  always_comb
  begin
    rst_pin_is_reset = !loaded || cfg[BIT_RST_FUNC];
    core_reset_n     = (state == ST_RUN) && (!rst_pin_is_reset || pin_n);
    clk_src_hs_int   = loaded && clk_code[1];
    clk_src_ext      = loaded && (clk_code == CLK_EXT);
    clk_src_xtal     = loaded && !var_b && (clk_code == CLK_XTAL);
    clk_sel_error    = loaded && var_b && (clk_code == CLK_XTAL);
    osc_in_pin_clk   = clk_src_xtal || clk_src_ext;
    osc_out_pin_clk  = clk_src_xtal && !var_b;
    if (var_b && loaded && !cfg[BIT_RST_FUNC])
      rst_pin_pullup_on = rst_port_pullup_bit;
    else
      rst_pin_pullup_on = var_b && loaded && cfg[BIT_PULLUP];
    slow_osc_run       = (loaded && lock) || !stop_bit;
    wdt_clk_force_slow = loaded && lock;
    if (wdt_clk_force_slow)
      wdt_clk_en = 1'b1;
    else
      wdt_clk_en = !halt_s && !stop_s && wdt_sel_slow && slow_osc_run;
    tmr8_clk_en = slow_osc_run;
  end

  chk_wait_bound: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_STAB) |-> (wait_cnt < wait_len))
    else $error("Oscillator wait counter overran its length.");

  chk_no_wait_int: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_STAB && clk_code[1]) |=> (state == ST_RUN))
    else $error("Wait inserted for internal oscillator.");

  chk_rst_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (state != ST_RUN) |-> !core_reset_n)
    else $error("Core left reset before configuration was loaded.");

  chk_pin_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    (loaded && cfg[BIT_RST_FUNC] && !pin_n) |-> !core_reset_n)
    else $error("Reset pin low did not hold core in reset.");

  chk_cfg_stable: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(loaded) |-> $stable(cfg))
    else $error("Configuration changed after it was latched.");

  chk_lock_run: assert property (@(posedge hclk) disable iff (!hresetn)
    (loaded && lock) |-> (slow_osc_run && wdt_clk_force_slow))
    else $error("Locked slow oscillator was stopped.");

  chk_wdt_gate: assert property (@(posedge hclk) disable iff (!hresetn)
    (loaded && !lock && (halt_s || stop_s || !wdt_sel_slow)) |-> !wdt_clk_en)
    else $error("Watchdog clock not gated.");

  chk_tmr_clk: assert property (@(posedge hclk) disable iff (!hresetn)
    (!stop_bit) |-> tmr8_clk_en)
    else $error("Interval timer lost its clock.");

  chk_xtal_pins: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_src_xtal |-> (osc_in_pin_clk && osc_out_pin_clk))
    else $error("Crystal source did not claim both pins.");

  chk_fetch_pin: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_FETCH && !pin_n) |=> (state == ST_FETCH))
    else $error("Fetch started while reset pin was low.");

  chk_wait_pin: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_WAIT && !pin_n) |=> (state == ST_FETCH))
    else $error("Fetch kept going while reset pin was low.");

  chk_flash_addr: assert property (@(posedge hclk) disable iff (!hresetn)
    flash_req |-> (flash_addr == CFG_FLASH_ADDR))
    else $error("Configuration fetched from the wrong address.");

  chk_xtal_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_STAB && !var_b && clk_code == CLK_XTAL && wait_cnt != wait_len - WAIT_W'(1)) |=> (state == ST_STAB))
    else $error("Crystal wait ended early.");

  chk_ext_no_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_STAB && clk_code == CLK_EXT) |=> (state == ST_RUN))
    else $error("Wait inserted for external clock.");

  chk_port_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == ST_RUN && !cfg[BIT_RST_FUNC]) |-> core_reset_n)
    else $error("Port-mode pin still reset the core.");

  chk_reset_func: assert property (@(posedge hclk) disable iff (!hresetn)
    (!loaded) |-> rst_pin_is_reset)
    else $error("Pin left its reset role before loading.");

  chk_clk_onehot: assert property (@(posedge hclk) disable iff (!hresetn)
    (loaded && !clk_sel_error) |-> $onehot({clk_src_xtal, clk_src_ext, clk_src_hs_int}))
    else $error("Clock source selection not one-hot.");

  chk_hs_pins: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_src_hs_int |-> (!osc_in_pin_clk && !osc_out_pin_clk))
    else $error("Internal oscillator claimed a shared pin.");

  chk_ext_pins: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_src_ext |-> (osc_in_pin_clk && !osc_out_pin_clk))
    else $error("External clock pin claim wrong.");

  chk_osc_stop: assert property (@(posedge hclk) disable iff (!hresetn)
    (loaded && !lock && stop_bit) |-> !slow_osc_run)
    else $error("Stoppable slow oscillator kept running.");

  chk_force_wdt: assert property (@(posedge hclk) disable iff (!hresetn)
    wdt_clk_force_slow |-> wdt_clk_en)
    else $error("Forced watchdog clock was gated.");

  chk_pullup_b: assert property (@(posedge hclk) disable iff (!hresetn)
    (loaded && var_b && cfg[BIT_RST_FUNC]) |-> (rst_pin_pullup_on == cfg[BIT_PULLUP]))
    else $error("Reset pin pull-up does not follow its bit.");

  chk_pullup_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (!var_b) |-> !rst_pin_pullup_on)
    else $error("Pull-up enabled on first variant.");

  chk_b_no_xtal: assert property (@(posedge hclk) disable iff (!hresetn)
    (loaded && var_b) |-> (!clk_src_xtal && !osc_out_pin_clk))
    else $error("Second variant selected a crystal.");

  chk_port_pullup: assert property (@(posedge hclk) disable iff (!hresetn)
    (loaded && var_b && !cfg[BIT_RST_FUNC]) |-> (rst_pin_pullup_on == rst_port_pullup_bit))
    else $error("Port pull-up not taken from port register.");

  chk_ack_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    (loaded && flash_ack) |=> (cfg == $past(cfg)))
    else $error("Late flash answer changed the configuration.");

  chk_idle_outputs: assert property (@(posedge hclk) disable iff (!hresetn)
    (!loaded) |-> (!clk_src_xtal && !clk_src_ext && !clk_src_hs_int && !wdt_clk_force_slow))
    else $error("Decoded control active before loading.");

endmodule // option_byte_config_decoder

// file: pkg/cfg_pkg.sv
// Constants for the configuration byte decoder: flash address, field layout, wait counts, register map.
// Assumes a 50 MHz hclk and a flash read port that answers a one-byte read some cycles after a request.
package cfg_pkg;
  localparam logic [15:0] CFG_FLASH_ADDR   = 16'h0080;
  localparam int          BIT_STAB_HI      = 6;
  localparam int          BIT_STAB_LO      = 5;
  localparam int          BIT_PULLUP       = 4;
  localparam int          BIT_RST_FUNC     = 3;
  localparam int          BIT_CLK_HI       = 2;
  localparam int          BIT_CLK_LO       = 1;
  localparam int          BIT_LOCK         = 0;
  localparam logic [1:0]  CLK_XTAL         = 2'h0;
  localparam logic [1:0]  CLK_EXT          = 2'h1;
  localparam int          WAIT_EXP_0       = 10;
  localparam int          WAIT_EXP_1       = 12;
  localparam int          WAIT_EXP_2       = 15;
  localparam int          WAIT_EXP_3       = 17;
  localparam int          WAIT_W           = 18;
  localparam logic [7:0]  CFG_BYTE_RESET   = 8'h00;
  localparam logic [31:0] REG_CFG_BYTE     = 32'h0000_0080;
  localparam logic [31:0] REG_STATUS       = 32'h0000_0000;
  localparam logic [31:0] REG_CTRL         = 32'h0000_0004;
  localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_WAIT  = 2'b01,
    ST_STAB  = 2'b10,
    ST_RUN   = 2'b11
  } load_state_t;
endpackage

// file: logic/pin_sync.sv
// Two-flop synchroniser for pin levels.
// Assumes the input is asynchronous to hclk.
module pin_sync
  import cfg_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic din,
  output logic      dout
);
  logic meta;
  logic next_meta;
  logic next_dout;

  always_comb
  begin
    next_meta = din;
    next_dout = meta;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta <= 1'b1;
      dout <= 1'b1;
    end
    else
    begin
      meta <= next_meta;
      dout <= next_dout;
    end
  end
endmodule // pin_sync

// file: logic/ahb_cfg_slave.sv
// AHB-Lite slave for the decoder's registers: one zero-wait read/write port.
// Assumes a single master, word transfers only; the response is always OKAY.
module ahb_cfg_slave
  import cfg_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [7:0]  cfg_byte,
  input  wire logic [7:0]  status,
  output logic             stop_bit
);
  logic        wr_pend;
  logic        next_wr_pend;
  logic        next_stop_bit;
  logic [31:0] next_hrdata;
  logic        take;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb
  begin
    take          = hsel && hready && htrans[1];
    next_wr_pend  = take && hwrite && (haddr == REG_CTRL);
    next_stop_bit = wr_pend ? hwdata[0] : stop_bit;
    next_hrdata   = 32'h0000_0000;
    if (take && !hwrite)
    begin
      case (haddr)
        REG_CFG_BYTE: next_hrdata = {24'h00_0000, cfg_byte};
        REG_STATUS:   next_hrdata = {24'h00_0000, status};
        REG_CTRL:     next_hrdata = {31'h0000_0000, next_stop_bit};
        default:      next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend  <= 1'b0;
      stop_bit <= 1'b0;
      hrdata   <= 32'h0000_0000;
    end
    else
    begin
      wr_pend  <= next_wr_pend;
      stop_bit <= next_stop_bit;
      hrdata   <= next_hrdata;
    end
  end
endmodule // ahb_cfg_slave

// file: tb/tb_option_byte_config_decoder.sv
// Testbench for the configuration byte decoder: loads bytes of both variants and checks the decoded controls.
// Assumes the zero-wait AHB-Lite port of the decoder and a flash that answers with a one-cycle ack pulse.
module tb_option_byte_config_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import cfg_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, variant_b, flash_req, flash_ack;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [15:0] flash_addr;
  logic [7:0]  flash_data;
  logic        rst_pin_n, halt_mode, stop_mode, wdt_sel_slow, rst_port_pullup_bit, core_reset_n;
  logic        clk_src_xtal, clk_src_ext, clk_src_hs_int, clk_sel_error, osc_in_pin_clk, osc_out_pin_clk;
  logic        rst_pin_is_reset, rst_pin_pullup_on, slow_osc_run, wdt_clk_en, wdt_clk_force_slow, tmr8_clk_en;
  int          error_cnt, n_tests;
  logic [8:0]  cases [8] = '{9'h091, 9'h0b9, 9'h0ba, 9'h0dc, 9'h0d1, 9'h1f7, 9'h1e9, 9'h1fa};

  assign hready = hreadyout;

  option_byte_config_decoder option_byte_config_decoder_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .variant_b(variant_b), .flash_req(flash_req), .flash_addr(flash_addr), .flash_ack(flash_ack),
    .flash_data(flash_data), .rst_pin_n(rst_pin_n), .halt_mode(halt_mode), .stop_mode(stop_mode),
    .wdt_sel_slow(wdt_sel_slow), .rst_port_pullup_bit(rst_port_pullup_bit), .core_reset_n(core_reset_n),
    .clk_src_xtal(clk_src_xtal), .clk_src_ext(clk_src_ext), .clk_src_hs_int(clk_src_hs_int),
    .clk_sel_error(clk_sel_error), .osc_in_pin_clk(osc_in_pin_clk), .osc_out_pin_clk(osc_out_pin_clk),
    .rst_pin_is_reset(rst_pin_is_reset), .rst_pin_pullup_on(rst_pin_pullup_on), .slow_osc_run(slow_osc_run),
    .wdt_clk_en(wdt_clk_en), .wdt_clk_force_slow(wdt_clk_force_slow), .tmr8_clk_en(tmr8_clk_en)
  );

  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk1(input string nm, input logic exp, input logic got);
    chk(nm, {31'h0, exp}, {31'h0, got});
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge hclk);
    @(negedge hclk);
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic load(input logic vb, input logic [7:0] b);
    int         n;
    int         wt;
    logic       sr;
    logic [1:0] cs;
    logic [31:0] rd;
    cs = b[2:1];
    wt = 1;
    if (!vb && cs == CLK_XTAL)
      wt = 1 << (b[6:5] == 2'h0 ? WAIT_EXP_0 : b[6:5] == 2'h1 ? WAIT_EXP_1 : b[6:5] == 2'h2 ? WAIT_EXP_2 : WAIT_EXP_3);
    @(posedge hclk);
    hresetn <= 1'b0;
    variant_b <= vb;
    rst_pin_n <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    n = 0;
    while (flash_req !== 1'b1 && n < 50)
    begin
      @(negedge hclk);
      n++;
    end
    chk("flash_addr", {16'h0, CFG_FLASH_ADDR}, {16'h0, flash_addr});
    settle(3);
    chk1("core_reset_n", 1'b0, core_reset_n);
    chk1("flash_req_held", 1'b0, flash_req);
    @(posedge hclk);
    rst_pin_n <= 1'b1;
    n = 0;
    while (flash_req !== 1'b1 && n < 50)
    begin
      @(negedge hclk);
      n++;
    end
    chk1("flash_req", 1'b1, flash_req);
    @(posedge hclk);
    flash_ack <= 1'b1;
    flash_data <= b;
    @(posedge hclk);
    flash_ack <= 1'b0;
    flash_data <= ~b;
    n = 0;
    while (core_reset_n !== 1'b1 && n < 140000)
    begin
      @(negedge hclk);
      n++;
    end
    chk("stab_wait", 32'h1, {31'h0, n >= wt && n <= wt + 4});
    @(posedge hclk);
    flash_ack <= 1'b1;
    @(posedge hclk);
    flash_ack <= 1'b0;
    ahb(1'b1, REG_CFG_BYTE, 32'hff, rd);
    ahb(1'b0, REG_CFG_BYTE, 32'h0, rd);
    chk("cfg_byte", {24'h0, b}, rd);
    ahb(1'b0, REG_STATUS, 32'h0, rd);
    chk("status", {28'h0, vb, vb && cs == 2'h0, 2'h3}, rd);
    ahb(1'b1, 32'h40, 32'h5, rd);
    ahb(1'b0, 32'h40, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    chk1("hresp", 1'b0, hresp);
    chk1("xtal", !vb && cs == CLK_XTAL, clk_src_xtal);
    chk1("ext", cs == CLK_EXT, clk_src_ext);
    chk1("hs_int", cs[1], clk_src_hs_int);
    chk1("sel_error", vb && cs == 2'h0, clk_sel_error);
    chk1("osc_in", vb ? cs == CLK_EXT : !cs[1], osc_in_pin_clk);
    chk1("osc_out", !vb && cs == CLK_XTAL, osc_out_pin_clk);
    chk1("rst_is_reset", b[3], rst_pin_is_reset);
    chk1("force_slow", b[0], wdt_clk_force_slow);
    for (int i = 0; i < 16; i++)
    begin
      ahb(1'b1, REG_CTRL, {31'h0, i[0]}, rd);
      halt_mode <= i[1];
      stop_mode <= i[2];
      wdt_sel_slow <= i[3];
      rst_port_pullup_bit <= i[0] ^ i[3];
      settle(4);
      sr = b[0] | !i[0];
      chk1("slow_osc_run", sr, slow_osc_run);
      chk1("wdt_clk_en", b[0] | (sr & i[3] & !i[1] & !i[2]), wdt_clk_en);
      chk1("tmr8_clk_en", sr, tmr8_clk_en);
      if (vb)
        chk1("pullup", b[3] ? b[4] : i[0] ^ i[3], rst_pin_pullup_on);
      else
        chk1("pullup_a", 1'b0, rst_pin_pullup_on);
    end
    ahb(1'b0, REG_CTRL, 32'h0, rd);
    chk("ctrl", 32'h1, rd);
    rst_pin_n <= 1'b0;
    settle(4);
    chk1("pin_reset", !b[3], core_reset_n);
    @(posedge hclk);
    rst_pin_n <= 1'b1;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    #1_600_000;
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    hresetn <= 1'b0;
    hsel <= 1'b0;
    haddr <= 32'h0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hwdata <= 32'h0;
    variant_b <= 1'b0;
    flash_ack <= 1'b0;
    flash_data <= 8'h00;
    rst_pin_n <= 1'b1;
    halt_mode <= 1'b0;
    stop_mode <= 1'b0;
    wdt_sel_slow <= 1'b0;
    rst_port_pullup_bit <= 1'b0;
    error_cnt = 0;
    n_tests = 0;
    foreach (cases[k])
      load(cases[k][8], cases[k][7:0]);
    report_and_stop();
  end
endmodule // tb_option_byte_config_decoder
